// File: rsm_defines.svh
// register offsets, field positions, reset values and timing counts
// included by the supply and reset monitor files; definitions only
`ifndef RSM_DEFINES_SVH
`define RSM_DEFINES_SVH

`define RSM_ADDR_W          8
`define RSM_OFF_SYS_CTRL    8'h00
`define RSM_OFF_SUPPLY_CFG  8'h04
`define RSM_OFF_INT_STATUS  8'h08
`define RSM_OFF_INT_MASK    8'h0C
`define RSM_OFF_STATE       8'h10

`define RSM_SYS_W           12
`define RSM_SYS_PAGE_LSB    0
`define RSM_SYS_PAGE_MSB    7
`define RSM_SYS_GFLAG       8
`define RSM_SYS_CLK_SUB     9
`define RSM_SYS_PERIPH_CLK  10
`define RSM_SYS_BOOSTER     11
`define RSM_SYS_CTRL_RST    12'h400

`define RSM_CFG_DET_EN      0
`define RSM_CFG_ACTION      1
`define RSM_CFG_UPPER       2
`define RSM_CFG_LOWER       3
`define RSM_ACTION_RESET    1'h0
`define RSM_ACTION_FREEZE   1'h1

`define RSM_INT_W           3
`define RSM_INT_UPPER       0
`define RSM_INT_LOWER       1
`define RSM_INT_WDT         2

`define RSM_MIN_LOW_CYC     8
`define RSM_STAB_TIME_US    65500
`define RSM_CLK_MHZ         25
`define RSM_STAB_EXTRA_CYC  7
`define RSM_VEC_LO_ADDR     16'hFFFE
`define RSM_VEC_HI_ADDR     16'hFFFF

`endif

// File: rsm_pkg.sv
// types shared by the supply and reset monitor
// no imports; users write rsm_pkg::name
package rsm_pkg;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_STAB,
        ST_VEC_LO,
        ST_VEC_HI,
        ST_VEC_LD,
        ST_RUN
    } rsm_state_t;

endpackage : rsm_pkg

// File: timer_if.sv
// control and status of one hold timer
// driven by the monitor top, served by hold_timer
`timescale 1ns/10ps

interface timer_if;
    logic clear;
    logic run;
    logic done;

    modport ctl (output clear, output run, input done);
    modport tmr (input clear, input run, output done);
endinterface : timer_if

// File: sync_2ff.sv
// two-flop synchroniser for one asynchronous level
// async reset forces the reset value, a constant
`timescale 1ns/10ps

module sync_2ff #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);

    logic meta_ff;
    logic q_ff;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_ff <= RST_VAL;
            q_ff    <= RST_VAL;
        end
        else
        begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;

endmodule : sync_2ff

// File: hold_timer.sv
// saturating cycle counter: done once run has held LIMIT cycles
// clear has priority; assumes one clock and a synchronised reset
`timescale 1ns/10ps

module hold_timer #(
    parameter int LIMIT = 8,
    parameter int W     = $clog2(LIMIT + 1)
) (
    input  wire logic clk,
    input  wire logic rst_n,
    timer_if.tmr      t
);

    localparam logic [W-1:0] LAST = W'(LIMIT - 1);

    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic         at_last;

    assign at_last = (cnt_ff == LAST);
    assign t.done  = at_last & t.run;
    assign nxt_cnt = t.clear ? '0 : ((t.run && !at_last) ? cnt_ff + W'(1) : cnt_ff);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_ff <= '0;
        else
            cnt_ff <= nxt_cnt;
    end

endmodule : hold_timer

// File: reset_supply_monitor.sv
// reset sequencer and supply level monitor with an APB register slave
// assumes one 25 MHz clock; pin and detector inputs are asynchronous
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "rsm_defines.svh"

module reset_supply_monitor #(
    parameter int STAB_CYCLES = `RSM_STAB_TIME_US * `RSM_CLK_MHZ + `RSM_STAB_EXTRA_CYC,
    parameter int LOW_CYCLES  = `RSM_MIN_LOW_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   reset_pin_n,
    input  wire logic                   wdt_reset_req,
    input  wire logic                   upper_det_raw,
    input  wire logic                   lower_det_raw,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`RSM_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic                        irq,
    output logic                        core_reset_n,
    output logic                        vec_rd,
    output logic      [15:0]            vec_addr,
    input  wire logic [7:0]             vec_data,
    output logic                        pc_load,
    output logic      [15:0]            pc_out,
    output logic                        ram_wr_block,
    output logic      [7:0]             ram_page_index,
    output logic                        page_select,
    output logic                        clk_sel_sub,
    output logic                        periph_clk_en,
    output logic                        booster_en,
    output logic                        supply_detector_en,
    output logic                        freeze,
    output logic                        upper_voltage_flag,
    output logic                        lower_voltage_sticky_flag
);

    logic                     rst_sync_n;
    logic                     pin_s;
    logic                     upper_s;
    logic                     lower_s;
    rsm_pkg::rsm_state_t      state_ff;
    rsm_pkg::rsm_state_t      nxt_state;
    logic                     low_done;
    logic                     stab_done;
    logic                     in_reset;
    logic                     brownout_rst;
    logic                     sys_rst_req;
    logic                     lower_set_evt;
    logic                     upper_rise_evt;
    logic [`RSM_SYS_W-1:0]    sys_ctrl_ff;
    logic [`RSM_SYS_W-1:0]    nxt_sys_ctrl;
    logic                     det_en_ff;
    logic                     nxt_det_en;
    logic                     action_ff;
    logic                     upper_flag_ff;
    logic                     lower_flag_ff;
    logic                     nxt_lower_flag;
    logic [`RSM_INT_W-1:0]    int_sts_ff;
    logic [`RSM_INT_W-1:0]    nxt_int_sts;
    logic [`RSM_INT_W-1:0]    int_mask_ff;
    logic [`RSM_INT_W-1:0]    int_evt;
    logic [7:0]               vec_lo_ff;
    logic [15:0]              pc_ff;
    logic                     pc_load_ff;
    logic [31:0]              prdata_ff;
    logic                     apb_setup;
    logic                     apb_wr;
    logic                     sel_sys;
    logic                     sel_cfg;
    logic                     sel_sts;
    logic                     sel_msk;
    logic                     sel_state;
    logic                     addr_hit;
    logic                     lower_clr_wr;
    logic [31:0]              rd_mux;

    // reset release and input synchronisers
    sync_2ff #(.RST_VAL(1'b0)) u_rst_sync (.clk(clk), .rst_n(rst_n), .d(1'b1), .q(rst_sync_n));
    sync_2ff #(.RST_VAL(1'b1)) u_pin_sync (.clk(clk), .rst_n(rst_sync_n), .d(reset_pin_n), .q(pin_s));
    sync_2ff #(.RST_VAL(1'b0)) u_upr_sync (.clk(clk), .rst_n(rst_sync_n), .d(upper_det_raw), .q(upper_s));
    sync_2ff #(.RST_VAL(1'b0)) u_lwr_sync (.clk(clk), .rst_n(rst_sync_n), .d(lower_det_raw), .q(lower_s));

    // pin low-time and stabilisation timers
    timer_if low_t ();
    timer_if stab_t ();

    assign low_t.clear  = pin_s;
    assign low_t.run    = !pin_s;
    assign low_done     = low_t.done;
    assign stab_t.clear = (state_ff != rsm_pkg::ST_STAB);
    assign stab_t.run   = (state_ff == rsm_pkg::ST_STAB);
    assign stab_done    = stab_t.done;

    hold_timer #(.LIMIT(LOW_CYCLES)) u_low_tmr (.clk(clk), .rst_n(rst_sync_n), .t(low_t));
    hold_timer #(.LIMIT(STAB_CYCLES)) u_stab_tmr (.clk(clk), .rst_n(rst_sync_n), .t(stab_t));

    // reset sources
    assign lower_set_evt = det_en_ff & lower_s & !lower_flag_ff;
    assign upper_rise_evt = det_en_ff & upper_s & !upper_flag_ff;
    assign brownout_rst  = lower_set_evt & (action_ff == `RSM_ACTION_RESET);
    assign sys_rst_req   = low_done | wdt_reset_req | brownout_rst;
    assign in_reset      = (state_ff == rsm_pkg::ST_RESET);

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            rsm_pkg::ST_RESET:  if (pin_s) nxt_state = rsm_pkg::ST_STAB;
            rsm_pkg::ST_STAB:   if (stab_done) nxt_state = rsm_pkg::ST_VEC_LO;
            rsm_pkg::ST_VEC_LO: nxt_state = rsm_pkg::ST_VEC_HI;
            rsm_pkg::ST_VEC_HI: nxt_state = rsm_pkg::ST_VEC_LD;
            rsm_pkg::ST_VEC_LD: nxt_state = rsm_pkg::ST_RUN;
            rsm_pkg::ST_RUN:    nxt_state = rsm_pkg::ST_RUN;
            default:            nxt_state = rsm_pkg::ST_RESET;
        endcase
        if (sys_rst_req)
            nxt_state = rsm_pkg::ST_RESET;
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            state_ff <= rsm_pkg::ST_RESET;
        else
            state_ff <= nxt_state;
    end

    // vector fetch: one-cycle read latency, low byte then high byte
    assign vec_rd   = (state_ff == rsm_pkg::ST_VEC_LO) | (state_ff == rsm_pkg::ST_VEC_HI);
    assign vec_addr = (state_ff == rsm_pkg::ST_VEC_HI) ? `RSM_VEC_HI_ADDR : `RSM_VEC_LO_ADDR;

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            vec_lo_ff  <= 8'h00;
            pc_ff      <= 16'h0000;
            pc_load_ff <= 1'b0;
        end
        else
        begin
            if (state_ff == rsm_pkg::ST_VEC_HI)
                vec_lo_ff <= vec_data;
            if (state_ff == rsm_pkg::ST_VEC_LD)
                pc_ff <= {vec_data, vec_lo_ff};
            pc_load_ff <= (state_ff == rsm_pkg::ST_VEC_LD) && !sys_rst_req;
        end
    end

    assign core_reset_n = (state_ff == rsm_pkg::ST_RUN);
    assign pc_load      = pc_load_ff;
    assign pc_out       = pc_ff;
    // RAM writes blocked, never cleared, while the core is held
    assign ram_wr_block = !core_reset_n;

    // APB decode
    assign apb_setup = psel & !penable;
    assign apb_wr    = psel & penable & pwrite;
    assign sel_sys   = (paddr == `RSM_OFF_SYS_CTRL);
    assign sel_cfg   = (paddr == `RSM_OFF_SUPPLY_CFG);
    assign sel_sts   = (paddr == `RSM_OFF_INT_STATUS);
    assign sel_msk   = (paddr == `RSM_OFF_INT_MASK);
    assign sel_state = (paddr == `RSM_OFF_STATE);
    assign addr_hit  = sel_sys | sel_cfg | sel_sts | sel_msk | sel_state;
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & !addr_hit;
    assign lower_clr_wr = apb_wr & sel_cfg & pwdata[`RSM_CFG_LOWER];

    assign rd_mux = sel_sys   ? {20'h00000, sys_ctrl_ff} :
                    sel_cfg   ? {28'h0000000, lower_flag_ff, upper_flag_ff, action_ff, det_en_ff} :
                    sel_sts   ? {29'h00000000, int_sts_ff} :
                    sel_msk   ? {29'h00000000, int_mask_ff} :
                    sel_state ? {pc_ff, 13'h0000, state_ff} :
                    32'h00000000;

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            prdata_ff <= 32'h00000000;
        else if (apb_setup)
            prdata_ff <= rd_mux;
    end

    assign prdata = prdata_ff;

    // system control, reinitialised by every system reset
    always_comb
    begin
        nxt_sys_ctrl = sys_ctrl_ff;
        nxt_det_en   = det_en_ff;
        if (apb_wr && sel_sys)
            nxt_sys_ctrl = pwdata[`RSM_SYS_W-1:0];
        if (apb_wr && sel_cfg)
            nxt_det_en = pwdata[`RSM_CFG_DET_EN];
        if (in_reset)
        begin
            nxt_sys_ctrl = `RSM_SYS_CTRL_RST;
            nxt_det_en   = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            sys_ctrl_ff <= `RSM_SYS_CTRL_RST;
            det_en_ff   <= 1'b1;
        end
        else
        begin
            sys_ctrl_ff <= nxt_sys_ctrl;
            det_en_ff   <= nxt_det_en;
        end
    end

    assign ram_page_index     = sys_ctrl_ff[`RSM_SYS_PAGE_MSB:`RSM_SYS_PAGE_LSB];
    assign page_select        = sys_ctrl_ff[`RSM_SYS_GFLAG];
    assign clk_sel_sub        = sys_ctrl_ff[`RSM_SYS_CLK_SUB];
    assign periph_clk_en      = sys_ctrl_ff[`RSM_SYS_PERIPH_CLK];
    assign booster_en         = sys_ctrl_ff[`RSM_SYS_BOOSTER];
    assign supply_detector_en = det_en_ff;

    // supply flags; action select and sticky flag survive system resets
    assign nxt_lower_flag = (det_en_ff & lower_s) | (lower_flag_ff & !lower_clr_wr);

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            upper_flag_ff <= 1'b0;
            lower_flag_ff <= 1'b0;
            action_ff     <= `RSM_ACTION_RESET;
        end
        else
        begin
            upper_flag_ff <= det_en_ff & upper_s;
            lower_flag_ff <= nxt_lower_flag;
            if (apb_wr && sel_cfg)
                action_ff <= pwdata[`RSM_CFG_ACTION];
        end
    end

    assign upper_voltage_flag        = upper_flag_ff;
    assign lower_voltage_sticky_flag = lower_flag_ff;
    assign freeze = lower_flag_ff & (action_ff == `RSM_ACTION_FREEZE);

    // interrupt status, write one to clear, set wins
    assign int_evt[`RSM_INT_UPPER] = upper_rise_evt;
    assign int_evt[`RSM_INT_LOWER] = lower_set_evt;
    assign int_evt[`RSM_INT_WDT]   = wdt_reset_req;
    assign nxt_int_sts = int_evt | (int_sts_ff & ~((apb_wr && sel_sts) ? pwdata[`RSM_INT_W-1:0] : 3'h0));

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            int_sts_ff  <= 3'h0;
            int_mask_ff <= 3'h0;
        end
        else
        begin
            int_sts_ff <= nxt_int_sts;
            if (apb_wr && sel_msk)
                int_mask_ff <= pwdata[`RSM_INT_W-1:0];
        end
    end

    assign irq = |(int_sts_ff & int_mask_ff);

    // checks
    localparam int STAB_LAST = STAB_CYCLES - 1;
    logic [31:0] stab_len_ff;

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            stab_len_ff <= 32'h00000000;
        else if (state_ff == rsm_pkg::ST_STAB)
            stab_len_ff <= stab_len_ff + 32'h00000001;
        else
            stab_len_ff <= 32'h00000000;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    sequence pin_low_held;
        (!pin_s)[*8];
    endsequence

    sequence vec_reads;
        (vec_rd && vec_addr == `RSM_VEC_LO_ADDR) ##1 (vec_rd && vec_addr == `RSM_VEC_HI_ADDR) ##1 !vec_rd;
    endsequence

    a_wdt_reset_entry: assert property (
        (wdt_reset_req && state_ff == rsm_pkg::ST_RUN) |=> (in_reset && !core_reset_n))
        else $error("watchdog request did not reset the core");

    a_pin_low_valid: assert property (
        pin_low_held |=> in_reset)
        else $error("pin held low did not enter reset");

    a_stab_wait_len: assert property (
        (state_ff == rsm_pkg::ST_STAB && nxt_state == rsm_pkg::ST_VEC_LO) |-> (stab_len_ff == STAB_LAST))
        else $error("stabilisation wait length wrong");

    a_vector_fetch: assert property (
        vec_reads ##1 (state_ff == rsm_pkg::ST_RUN) |->
        (pc_load && pc_out == {$past(vec_data, 1), $past(vec_data, 2)}))
        else $error("program counter not loaded from vector");

    a_ram_write_block: assert property (
        (state_ff != rsm_pkg::ST_RUN) |-> ram_wr_block)
        else $error("RAM writes open during reset");

    a_reset_defaults: assert property (
        in_reset |=> (ram_page_index == 8'h00 && !page_select && !clk_sel_sub && periph_clk_en
                      && !booster_en && supply_detector_en))
        else $error("reset defaults not applied");

    a_detect_disable: assert property (
        (!supply_detector_en)[*2] |-> (!upper_voltage_flag && !$rose(lower_voltage_sticky_flag)))
        else $error("flag set while detection disabled");

    a_upper_follow: assert property (
        (supply_detector_en && $past(supply_detector_en)) |-> (upper_voltage_flag == $past(upper_det_raw, 3)))
        else $error("upper flag does not follow supply");

    a_lower_sticky: assert property (
        (lower_voltage_sticky_flag && !lower_clr_wr) |=> lower_voltage_sticky_flag)
        else $error("lower flag dropped without software");

    a_lower_sw_clear: assert property (
        $fell(lower_voltage_sticky_flag) |-> $past(lower_clr_wr))
        else $error("lower flag cleared by hardware");

    a_brownout_action: assert property (
        $rose(lower_voltage_sticky_flag) |->
        (freeze ? ($past(action_ff) == `RSM_ACTION_FREEZE) : (in_reset || $past(in_reset))))
        else $error("brownout action not taken");

    a_pin_sync_delay: assert property (
        $fell(pin_s) |-> $past(!reset_pin_n, 2))
        else $error("pin reached logic without two flops");

endmodule : reset_supply_monitor

// File: rsm_partner.sv
// reset pin, supply comparators and vector memory around the monitor
// assumes one clock; the bench commands pin and supply levels
`timescale 1ns/10ps

module rsm_partner #(
    parameter logic [7:0] VEC_LO = 8'h34,
    parameter logic [7:0] VEC_HI = 8'hC2
) (
    input  wire logic        clk,
    input  wire logic        pin_low,
    input  wire logic        below_upper,
    input  wire logic        below_lower,
    input  wire logic        vec_rd,
    input  wire logic [15:0] vec_addr,
    output logic             reset_pin_n,
    output logic             upper_det_raw,
    output logic             lower_det_raw,
    output logic      [7:0]  vec_data
);
    // pin has a pull-up: released means high
    assign reset_pin_n   = ~pin_low;
    assign upper_det_raw = below_upper;
    assign lower_det_raw = below_lower;

    // one cycle of read latency; junk that toggles when not read
    always_ff @(posedge clk)
    begin
        if (vec_rd)
            vec_data <= (vec_addr == 16'hFFFE) ? VEC_LO : VEC_HI;
        else
            vec_data <= ~vec_data;
    end
endmodule : rsm_partner

// File: reset_supply_monitor_test.sv
// self-checking bench for the reset sequencer and supply monitor
// assumes rsm_partner as far side and the APB register map of the design
`timescale 1ns/10ps
`include "rsm_defines.svh"

module reset_supply_monitor_test;
    localparam int STAB = 20;
    logic clk, rst_n, pin_low, below_upper, below_lower, wdt_reset_req;
    logic psel, penable, pwrite, pready, pslverr, irq, core_reset_n, vec_rd, pc_load;
    logic ram_wr_block, page_select, clk_sel_sub, periph_clk_en, booster_en, supply_detector_en;
    logic freeze, upper_voltage_flag, lower_voltage_sticky_flag, reset_pin_n, upper_det_raw, lower_det_raw;
    logic [7:0]  paddr, vec_data, ram_page_index;
    logic [15:0] vec_addr, pc_out;
    logic [31:0] pwdata, prdata, rd, seed;
    logic        err;
    int          num_errors, checks, n;

    reset_supply_monitor #(.STAB_CYCLES(STAB), .LOW_CYCLES(8)) u_reset_supply_monitor (
        .clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .wdt_reset_req(wdt_reset_req),
        .upper_det_raw(upper_det_raw), .lower_det_raw(lower_det_raw), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .core_reset_n(core_reset_n), .vec_rd(vec_rd), .vec_addr(vec_addr), .vec_data(vec_data),
        .pc_load(pc_load), .pc_out(pc_out), .ram_wr_block(ram_wr_block), .ram_page_index(ram_page_index),
        .page_select(page_select), .clk_sel_sub(clk_sel_sub), .periph_clk_en(periph_clk_en),
        .booster_en(booster_en), .supply_detector_en(supply_detector_en), .freeze(freeze),
        .upper_voltage_flag(upper_voltage_flag), .lower_voltage_sticky_flag(lower_voltage_sticky_flag));
    rsm_partner u_rsm_partner (.clk(clk), .pin_low(pin_low), .below_upper(below_upper),
        .below_lower(below_lower), .vec_rd(vec_rd), .vec_addr(vec_addr), .reset_pin_n(reset_pin_n),
        .upper_det_raw(upper_det_raw), .lower_det_raw(lower_det_raw), .vec_data(vec_data));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic summarize();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: %s got %0h", $time, what, got);
        end
    endtask : chk

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        chk(k < 50, 1, "apb ready timeout");
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wait_core(input logic lvl, input int max);
        n = 0;
        while (core_reset_n !== lvl && n < max)
        begin
            @(posedge clk);
            n++;
        end
        chk(n < max, 1, "core reset level");
    endtask : wait_core

    task automatic boot();
        wait_core(1'b1, STAB + 40);
        chk(n >= STAB, 1, "stabilisation wait");
        chk(pc_load, 1'b1, "pc load pulse");
        chk(pc_out, 16'hC234, "pc from vector");
        chk({ram_page_index, page_select, clk_sel_sub, booster_en}, 0, "page and clock defaults");
        chk({periph_clk_en, supply_detector_en}, 2'h3, "peripheral clock and detector on");
    endtask : boot

    task automatic supply(input logic up, input logic lo);
        below_upper <= up;
        below_lower <= lo;
        repeat (6) @(posedge clk);
    endtask : supply

    initial
    begin
        #(40 * 20000);
        num_errors++;
        summarize();
    end

    initial
    begin
        {rst_n, pin_low, below_upper, below_lower, wdt_reset_req, psel, penable, pwrite} = '0;
        paddr  = '0;
        pwdata = '0;
        seed   = 32'h72CB1DE3;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        boot();
        chk(ram_wr_block, 1'b0, "ram open in run");
        apb(`RSM_OFF_STATE, 1'b0, 0);
        chk(rd, 32'hC2340005, "state and pc readback");
        repeat (4)
        begin
            seed = lfsr(seed);
            apb(`RSM_OFF_SYS_CTRL, 1'b1, seed);
            apb(`RSM_OFF_SYS_CTRL, 1'b0, 0);
            chk(rd, {20'h0, seed[11:0]}, "system control readback");
            chk(ram_page_index, seed[7:0], "page index port");
            chk({booster_en, periph_clk_en, clk_sel_sub, page_select}, seed[11:8], "control field ports");
        end
        wdt_reset_req <= 1'b1;
        @(posedge clk);
        wdt_reset_req <= 1'b0;
        wait_core(1'b0, 4);
        chk(ram_wr_block, 1'b1, "ram writes held off in reset");
        boot();
        apb(`RSM_OFF_SYS_CTRL, 1'b0, 0);
        chk(rd, 32'h400, "system control after reset");
        apb(`RSM_OFF_INT_STATUS, 1'b0, 0);
        chk(rd[2], 1'b1, "watchdog event");
        apb(`RSM_OFF_INT_STATUS, 1'b1, 32'h7);
        apb(`RSM_OFF_INT_STATUS, 1'b0, 0);
        chk(rd, 0, "status cleared");
        apb(8'h14, 1'b0, 0);
        chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
        seed = lfsr(seed);
        pin_low <= 1'b1;
        repeat (1 + seed % 7) @(posedge clk);
        pin_low <= 1'b0;
        n = 0;
        repeat (16)
        begin
            @(posedge clk);
            n += (core_reset_n !== 1'b1);
        end
        chk(n, 0, "short pin pulse ignored");
        pin_low <= 1'b1;
        repeat (8 + seed[2:0]) @(posedge clk);
        pin_low <= 1'b0;
        wait_core(1'b0, 6);
        boot();
        apb(`RSM_OFF_INT_MASK, 1'b1, 32'h3);
        supply(1'b1, 1'b0);
        chk({upper_voltage_flag, irq}, 2'h3, "upper flag and interrupt");
        supply(1'b0, 1'b0);
        chk(upper_voltage_flag, 1'b0, "upper flag follows supply");
        apb(`RSM_OFF_INT_STATUS, 1'b1, 32'h3);
        chk(irq, 1'b0, "interrupt cleared");
        apb(`RSM_OFF_SUPPLY_CFG, 1'b1, 32'h0);
        supply(1'b1, 1'b0);
        chk({supply_detector_en, upper_voltage_flag}, 0, "detector disabled");
        apb(`RSM_OFF_SUPPLY_CFG, 1'b1, 32'h3);
        supply(1'b0, 1'b1);
        chk({lower_voltage_sticky_flag, freeze, core_reset_n}, 3'h7, "freeze on low supply");
        apb(`RSM_OFF_SUPPLY_CFG, 1'b0, 0);
        chk(rd, 32'hB, "supply config readback");
        supply(1'b0, 1'b0);
        chk(lower_voltage_sticky_flag, 1'b1, "lower flag sticky");
        apb(`RSM_OFF_SUPPLY_CFG, 1'b1, 32'hB);
        repeat (2) @(posedge clk);
        chk({lower_voltage_sticky_flag, freeze}, 0, "lower flag cleared by write");
        apb(`RSM_OFF_SUPPLY_CFG, 1'b1, 32'h1);
        below_lower <= 1'b1;
        wait_core(1'b0, 10);
        below_lower <= 1'b0;
        boot();
        chk(lower_voltage_sticky_flag, 1'b1, "lower flag survives reset");
        summarize();
    end
endmodule : reset_supply_monitor_test
